/* hw/ioac_pkg.sv */
package ioac_pkg;
   // Frame geometry
   localparam int FRAME_BYTES = 9;            // Command and reply length
   localparam int CNT_W       = 4;            // Byte counter width
   localparam logic [3:0] LAST_IDX = 4'h8;    // Index of checksum byte
   // Instruction codes
   localparam logic [7:0] INSTR_SET_OUT  = 8'h0E;
   localparam logic [7:0] INSTR_READ_IN  = 8'h0F;
   localparam logic [7:0] INSTR_ACC_OP   = 8'h13;
   // Banks and special port
   localparam logic [7:0] BANK_DIG_IN    = 8'h00;
   localparam logic [7:0] BANK_ANALOG    = 8'h01;
   localparam logic [7:0] BANK_OUT       = 8'h02;
   localparam logic [7:0] PORT_ALL       = 8'hFF;
   localparam logic [31:0] VAL_FROM_ACC  = 32'hFFFFFFFF;
   // Status codes
   localparam logic [7:0] ST_OK          = 8'h64;   // 100, success
   localparam logic [7:0] ST_BAD_CSUM    = 8'h01;
   localparam logic [7:0] ST_BAD_CMD     = 8'h02;
   localparam logic [7:0] ST_BAD_TYPE    = 8'h03;
   localparam logic [7:0] ST_BAD_VALUE   = 8'h04;
   // Reset values
   localparam logic [31:0] ACC_RESET     = 32'h00000000;
   localparam logic [3:0]  OUT_RESET     = 4'h0;
   localparam logic [7:0]  HOST_ADDR_DEF = 8'h02;
   localparam logic [7:0]  TARGET_ADDR_DEF = 8'h01;
   // Accumulator operations
   typedef enum logic [3:0] {
      OP_ADD = 4'h0, OP_SUB = 4'h1, OP_MULTIPLY = 4'h2, OP_DIV = 4'h3,
      OP_REMAINDER = 4'h4, OP_AND = 4'h5, OP_OR = 4'h6, OP_XOR = 4'h7,
      OP_NOT = 4'h8, OP_LOAD = 4'h9
   } ioac_op_t;
   // Main sequencer, Gray along receive, execute, reply
   typedef enum logic [1:0] {
      ST_RX = 2'b00, ST_EXEC = 2'b01, ST_TX = 2'b11
   } ioac_state_t;
endpackage

/* hw/ioac_sync.sv */
`timescale 1ns/1ns
// Two-flop synchroniser for asynchronous pin levels
module ioac_sync #(
   parameter int W = 1
) (
   input  wire logic         clock,
   input  wire logic         rst_b,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] meta_q;   // First stage, read only by second stage
   logic [W-1:0] meta_d;
   logic [W-1:0] sync_q;   // Second stage, safe for logic
   logic [W-1:0] sync_d;

   // Next values
   always_comb begin
      meta_d = async_in;
      sync_d = meta_q;
   end

   // Registers, synchronous reset
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign sync_out = sync_q;
endmodule

/* hw/ioac_cmd_unit.sv */
`timescale 1ns/1ns
// Command interpreter for output set, port read and accumulator ops
module ioac_cmd_unit (
   input  wire logic        clock,
   input  wire logic        rst_b,
   // Command byte stream
   input  wire logic        cmd_valid,      // Command byte offered
   input  wire logic [7:0]  cmd_byte,       // Byte, frame order
   output logic             cmd_ready,      // Byte taken when high
   input  wire logic        standalone,     // High: stored program source
   input  wire logic [7:0]  host_addr,      // Host address for replies
   // Reply byte stream
   output logic             rep_valid,      // Reply byte present
   output logic [7:0]       rep_byte,       // Reply byte
   input  wire logic        rep_ready,      // Host takes reply byte
   output logic             exec_done,      // One cycle pulse per command
   // Pins
   output logic             gp_out_0,
   output logic             gp_out_1,
   output logic             gp_out_2,
   output logic             gp_out_3,
   input  wire logic        gp_in_0,
   input  wire logic        gp_in_1,
   input  wire logic        gp_in_2,
   input  wire logic        gp_in_3,
   input  wire logic        analog_in_0,    // Digital level of analog line
   input  wire logic        analog_in_1,
   input  wire logic [11:0] adc_value_0,    // Converter results, same clock
   input  wire logic [11:0] adc_value_1,
   output logic [31:0]      accumulator     // Accumulator state
);
   logic [5:0] pins_s;   // Synchronised: analog_in_1, analog_in_0, gp_in_3..0

   // Pin levels cross into the clock domain first
   ioac_sync #(.W(6)) u_sync (
      .clock    (clock),
      .rst_b    (rst_b),
      .async_in ({analog_in_1, analog_in_0, gp_in_3, gp_in_2, gp_in_1, gp_in_0}),
      .sync_out (pins_s)
   );

   ioac_pkg::ioac_state_t state_q, state_d;   // Sequencer
   logic [7:0]  frame_q [0:8];                // Received command bytes
   logic [7:0]  frame_d [0:8];
   logic [3:0]  cnt_q, cnt_d;                 // Byte index
   logic [7:0]  sum_q, sum_d;                 // Running checksum
   logic [31:0] acc_q, acc_d;                 // Accumulator
   logic [3:0]  out_q, out_d;                 // Driven outputs
   logic [7:0]  rep_q [0:8];                  // Reply frame
   logic [7:0]  rep_d [0:8];
   logic        done_q, done_d;
   logic [7:0]  byte_q, byte_d;               // Reply byte as seen on the port
   logic        sa_q, sa_d;                   // Source latched at frame start

   // Decoded fields
   logic [7:0]  f_instr, f_type, f_bank;
   logic [31:0] f_val;
   assign f_instr = frame_q[1];
   assign f_type  = frame_q[2];
   assign f_bank  = frame_q[3];
   assign f_val   = {frame_q[4], frame_q[5], frame_q[6], frame_q[7]};   // MSB first

   // Read-port result and validity
   logic [31:0] rd_val;
   logic        rd_ok;
   always_comb begin
      rd_val = 32'h00000000;
      rd_ok  = 1'b1;
      case (f_bank)
         ioac_pkg::BANK_DIG_IN: begin
            if (f_type < 8'h02)
               rd_val = {31'h0, pins_s[4 + f_type[0]]};   // Digital view of analog line
            else if (f_type < 8'h06)
               rd_val = {31'h0, pins_s[f_type[1:0] - 2'h2]};
            else if (f_type == ioac_pkg::PORT_ALL)
               rd_val = {28'h0, pins_s[3:0]};   // The four gp inputs in low bits; analog lines not included
            else
               rd_ok = 1'b0;
         end
         ioac_pkg::BANK_ANALOG: begin
            if (f_type == 8'h00)
               rd_val = {20'h0, adc_value_0};   // 0..4095
            else if (f_type == 8'h01)
               rd_val = {20'h0, adc_value_1};
            else
               rd_ok = 1'b0;
         end
         ioac_pkg::BANK_OUT: begin
            if (f_type < 8'h04)
               rd_val = {31'h0, out_q[f_type[1:0]]};
            else
               rd_ok = 1'b0;
         end
         default: rd_ok = 1'b0;
      endcase
   end

   // Accumulator operation result; divide by zero leaves accumulator
   logic [31:0] op_val;
   logic        op_ok;
   logic [63:0] prod;
   assign prod = $signed(acc_q) * $signed(f_val);
   always_comb begin
      op_val = acc_q;
      op_ok  = 1'b1;
      case (f_type)
         8'h00: op_val = acc_q + f_val;
         8'h01: op_val = acc_q - f_val;
         8'h02: op_val = prod[31:0];
         8'h03: if (f_val != 32'h0) op_val = $signed(acc_q) / $signed(f_val);
         8'h04: if (f_val != 32'h0) op_val = $signed(acc_q) % $signed(f_val);
         8'h05: op_val = acc_q & f_val;
         8'h06: op_val = acc_q | f_val;
         8'h07: op_val = acc_q ^ f_val;
         8'h08: op_val = ~acc_q;
         8'h09: op_val = f_val;
         default: op_ok = 1'b0;
      endcase
   end

   // Next state for sequencer and data path
   always_comb begin
      state_d = state_q;
      frame_d = frame_q;
      rep_d   = rep_q;
      cnt_d   = cnt_q;
      sum_d   = sum_q;
      acc_d   = acc_q;
      out_d   = out_q;
      done_d  = 1'b0;
      sa_d    = sa_q;
      case (state_q)
         ioac_pkg::ST_RX: begin
            if (cmd_valid) begin
               frame_d[cnt_q] = cmd_byte;
               if (cnt_q == 4'h0)
                  sa_d = standalone;
               if (cnt_q == ioac_pkg::LAST_IDX) begin
                  state_d = ioac_pkg::ST_EXEC;
                  cnt_d   = 4'h0;
               end else begin
                  sum_d = sum_q + cmd_byte;
                  cnt_d = cnt_q + 4'h1;
               end
            end
         end
         ioac_pkg::ST_EXEC: begin
            rep_d[0] = host_addr;
            rep_d[1] = frame_q[0];
            rep_d[2] = ioac_pkg::ST_OK;
            rep_d[3] = f_instr;
            {rep_d[4], rep_d[5], rep_d[6], rep_d[7]} = 32'h0;
            done_d   = 1'b1;
            if (frame_q[8] != sum_q)
               rep_d[2] = ioac_pkg::ST_BAD_CSUM;
            else if (f_instr == ioac_pkg::INSTR_SET_OUT) begin
               if (f_bank != ioac_pkg::BANK_OUT)
                  rep_d[2] = ioac_pkg::ST_BAD_TYPE;
               else if (f_type == ioac_pkg::PORT_ALL) begin
                  if (f_val == ioac_pkg::VAL_FROM_ACC)
                     out_d = acc_q[3:0];
                  else if (f_val < 32'h100)
                     out_d = f_val[3:0];
                  else
                     rep_d[2] = ioac_pkg::ST_BAD_VALUE;
               end else if (f_type < 8'h04) begin
                  if (f_val < 32'h2)
                     out_d[f_type[1:0]] = f_val[0];
                  else
                     rep_d[2] = ioac_pkg::ST_BAD_VALUE;
               end else
                  rep_d[2] = ioac_pkg::ST_BAD_TYPE;
            end else if (f_instr == ioac_pkg::INSTR_READ_IN) begin
               if (!rd_ok)
                  rep_d[2] = ioac_pkg::ST_BAD_TYPE;
               else begin
                  if (sa_q || (f_type == ioac_pkg::PORT_ALL))
                     acc_d = rd_val;
                  else
                     {rep_d[4], rep_d[5], rep_d[6], rep_d[7]} = rd_val;
               end
            end else if (f_instr == ioac_pkg::INSTR_ACC_OP) begin
               if (!op_ok)
                  rep_d[2] = ioac_pkg::ST_BAD_TYPE;
               else begin
                  acc_d = op_val;
                  {rep_d[4], rep_d[5], rep_d[6], rep_d[7]} = f_val;
               end
            end else
               rep_d[2] = ioac_pkg::ST_BAD_CMD;
            rep_d[8] = rep_d[0] + rep_d[1] + rep_d[2] + rep_d[3] + rep_d[4]
                       + rep_d[5] + rep_d[6] + rep_d[7];
            sum_d   = 8'h00;
            state_d = sa_q ? ioac_pkg::ST_RX : ioac_pkg::ST_TX;   // No reply in standalone
         end
         ioac_pkg::ST_TX: begin
            if (rep_ready) begin
               if (cnt_q == ioac_pkg::LAST_IDX) begin
                  cnt_d   = 4'h0;
                  state_d = ioac_pkg::ST_RX;
               end else
                  cnt_d = cnt_q + 4'h1;
            end
         end
         default: state_d = ioac_pkg::ST_RX;
      endcase
      // Reply byte picked one step ahead, so the port is driven by a flop and not by a mux
      byte_d = (state_d == ioac_pkg::ST_TX) ? rep_d[cnt_d] : 8'h00;
   end

   // Registers
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         state_q <= ioac_pkg::ST_RX;
         for (int i = 0; i < ioac_pkg::FRAME_BYTES; i++) begin
            frame_q[i] <= 8'h00;
            rep_q[i]   <= 8'h00;
         end
         cnt_q  <= 4'h0;
         sum_q  <= 8'h00;
         acc_q  <= ioac_pkg::ACC_RESET;
         out_q  <= ioac_pkg::OUT_RESET;
         done_q <= 1'b0;
         sa_q   <= 1'b0;
         byte_q <= 8'h00;
      end else begin
         state_q <= state_d;
         frame_q <= frame_d;
         rep_q   <= rep_d;
         cnt_q   <= cnt_d;
         sum_q   <= sum_d;
         acc_q   <= acc_d;
         out_q   <= out_d;
         done_q  <= done_d;
         sa_q    <= sa_d;
         byte_q  <= byte_d;
      end
   end

   // Outputs; reply byte comes straight from its own flop
   assign cmd_ready   = (state_q == ioac_pkg::ST_RX);
   assign rep_valid   = (state_q == ioac_pkg::ST_TX);
   assign rep_byte    = byte_q;
   assign exec_done   = done_q;
   assign accumulator = acc_q;
   assign {gp_out_3, gp_out_2, gp_out_1, gp_out_0} = out_q;

   // Assertions
   property p_ld;
      @(posedge clock) disable iff (!rst_b)
      (state_q == ioac_pkg::ST_EXEC && frame_q[8] == sum_q && f_instr == ioac_pkg::INSTR_ACC_OP
       && f_type == 8'h09) |=> (acc_q == $past(f_val));
   endproperty
   a_ld: assert property (p_ld) else $error("load did not reach accumulator");
   property p_dir_rd;
      @(posedge clock) disable iff (!rst_b)
      (state_q == ioac_pkg::ST_EXEC && !sa_q && f_instr == ioac_pkg::INSTR_READ_IN
       && f_type != ioac_pkg::PORT_ALL) |=> $stable(acc_q);
   endproperty
   a_dir_rd: assert property (p_dir_rd) else $error("direct read changed accumulator");
   property p_ok;
      @(posedge clock) disable iff (!rst_b)
      (state_q == ioac_pkg::ST_EXEC && frame_q[8] == sum_q && f_instr == ioac_pkg::INSTR_ACC_OP && op_ok)
      |=> (rep_q[2] == ioac_pkg::ST_OK && {rep_q[4], rep_q[5], rep_q[6], rep_q[7]} == $past(f_val));
   endproperty
   a_ok: assert property (p_ok) else $error("op reply wrong");
   property p_csum;
      @(posedge clock) disable iff (!rst_b)
      (state_q == ioac_pkg::ST_TX) |-> (rep_q[8] == 8'(rep_q[0] + rep_q[1] + rep_q[2] + rep_q[3]
       + rep_q[4] + rep_q[5] + rep_q[6] + rep_q[7]));
   endproperty
   a_csum: assert property (p_csum) else $error("reply checksum wrong");
   property p_bit;
      @(posedge clock) disable iff (!rst_b)
      (state_q == ioac_pkg::ST_EXEC && frame_q[8] == sum_q && f_instr == ioac_pkg::INSTR_SET_OUT
       && f_bank == ioac_pkg::BANK_OUT && f_type < 8'h04 && f_val < 32'h2)
      |=> (out_q[$past(f_type[1:0])] == $past(f_val[0]));
   endproperty
   a_bit: assert property (p_bit) else $error("output bit not set");
   property p_acc_out;
      @(posedge clock) disable iff (!rst_b)
      (state_q == ioac_pkg::ST_EXEC && frame_q[8] == sum_q && f_instr == ioac_pkg::INSTR_SET_OUT
       && f_bank == ioac_pkg::BANK_OUT && f_type == ioac_pkg::PORT_ALL && f_val == ioac_pkg::VAL_FROM_ACC)
      |=> (out_q == $past(acc_q[3:0]));
   endproperty
   a_acc_out: assert property (p_acc_out) else $error("outputs not from accumulator");
   property p_hdr;
      @(posedge clock) disable iff (!rst_b)
      (state_q == ioac_pkg::ST_TX) |-> (rep_q[1] == frame_q[0] && rep_q[3] == frame_q[1]);
   endproperty
   a_hdr: assert property (p_hdr) else $error("reply header wrong");
   property p_all_in;
      @(posedge clock) disable iff (!rst_b)
      (state_q == ioac_pkg::ST_EXEC && frame_q[8] == sum_q && f_instr == ioac_pkg::INSTR_READ_IN
       && f_bank == ioac_pkg::BANK_DIG_IN && f_type == ioac_pkg::PORT_ALL)
      |=> (acc_q[31:4] == 28'h0);
   endproperty
   a_all_in: assert property (p_all_in) else $error("input pack wrong");
   // Stored program read must land in the accumulator
   property p_sa_rd;
      @(posedge clock) disable iff (!rst_b)
      (state_q == ioac_pkg::ST_EXEC && frame_q[8] == sum_q && sa_q
       && f_instr == ioac_pkg::INSTR_READ_IN && rd_ok)
      |=> (acc_q == $past(rd_val));
   endproperty
   a_sa_rd: assert property (p_sa_rd) else $error("stored read missed accumulator");
   // A spoiled frame must leave outputs and accumulator alone
   property p_bad_sum;
      @(posedge clock) disable iff (!rst_b)
      (state_q == ioac_pkg::ST_EXEC && frame_q[8] != sum_q) |=> ($stable(out_q) && $stable(acc_q));
   endproperty
   a_bad_sum: assert property (p_bad_sum) else $error("spoiled frame had an effect");
   // Direct converter read puts the result in the reply value
   property p_adc;
      @(posedge clock) disable iff (!rst_b)
      (state_q == ioac_pkg::ST_EXEC && frame_q[8] == sum_q && !sa_q && f_instr == ioac_pkg::INSTR_READ_IN
       && f_bank == ioac_pkg::BANK_ANALOG && f_type == 8'h00)
      |=> ({rep_q[4], rep_q[5], rep_q[6], rep_q[7]} == {20'h0, $past(adc_value_0)});
   endproperty
   a_adc: assert property (p_adc) else $error("converter reply wrong");
   // Port byte always matches the reply slot being offered
   property p_byte;
      @(posedge clock) disable iff (!rst_b)
      (state_q == ioac_pkg::ST_TX) |-> (rep_byte == rep_q[cnt_q]);
   endproperty
   a_byte: assert property (p_byte) else $error("reply byte out of order");
   c_tx: cover property (@(posedge clock) state_q == ioac_pkg::ST_TX && cnt_q == ioac_pkg::LAST_IDX && rep_ready);
   c_err: cover property (@(posedge clock) state_q == ioac_pkg::ST_TX && rep_q[2] != ioac_pkg::ST_OK);
   c_op: cover property (@(posedge clock) done_q && rep_q[3] == ioac_pkg::INSTR_ACC_OP);
   c_sa: cover property (@(posedge clock) state_q == ioac_pkg::ST_EXEC && sa_q);
endmodule

/* test/ioac_host_model.sv */
`timescale 1ns/1ns
// Host side: sends command frames and takes reply bytes at a varying pace
module ioac_host_model (
   clock,
   cmd_ready,
   cmd_valid,
   cmd_byte,
   standalone,
   rep_ready
);
   input  wire logic       clock;
   input  wire logic       cmd_ready;
   output logic            cmd_valid;   // Byte offered
   output logic [7:0]      cmd_byte;    // Frame byte
   output logic            standalone;  // Frame source
   output logic            rep_ready;   // Reply byte taken
   logic        [7:0]      fr [9];      // Frame being sent

   // Quiet lines at time zero
   initial begin
      cmd_valid = 1'b0;
      cmd_byte = 8'h00;
      standalone = 1'b0;
      rep_ready = 1'b0;
   end

   // Stall about one reply byte in four, so slow and prompt hosts are both seen
   always @(negedge clock) begin
      rep_ready <= ($urandom % 4) != 0;
   end

   // One whole frame; bad spoils the checksum on purpose
   task automatic send(input logic sa, input logic [7:0] ins, typ, bnk, input logic [31:0] val,
                       input bit bad, output bit ok);
      int n;
      fr = '{8'h01, ins, typ, bnk, val[31:24], val[23:16], val[15:8], val[7:0], 8'h00};
      for (int i = 0; i < 8; i++) begin
         fr[8] += fr[i];
      end
      fr[8] += {7'h00, bad};
      ok = 1'b1;
      for (int i = 0; i < 9; i++) begin
         @(negedge clock);
         cmd_valid = 1'b1;
         cmd_byte = fr[i];
         standalone = sa;
         n = 0;
         // Byte stays put until a ready edge takes it
         while (cmd_ready !== 1'b1 && n < 200) begin
            @(negedge clock);
            n++;
         end
         if (n >= 200) begin
            ok = 1'b0;
         end
         @(posedge clock);
      end
      @(negedge clock);
      cmd_valid = 1'b0;
      // Released line shows no stale byte
      cmd_byte = ~cmd_byte;
   endtask
endmodule

/* test/test_io_and_accumulator_command_unit.sv */
`timescale 1ns/1ns
// Self-checking bench for the command unit
module test_io_and_accumulator_command_unit;
   logic        clock, rst_b, cmd_valid, cmd_ready, standalone, rep_valid, rep_ready, exec_done;
   logic [7:0]  cmd_byte, rep_byte, host_addr;
   wire  [3:0]  gp_out;                // Output pins, one port per bit
   logic [3:0]  gp_in, g;              // Input pins, saved outputs
   logic [1:0]  ain;                   // Digital levels of analog lines
   logic [11:0] adc0, adc1;            // Converter results
   logic [31:0] accumulator, a, v, x;  // Acc pin, saved acc, operand, model acc
   logic [8:0]  exp_q[$];              // Bit 8 clear marks a don't-care byte
   logic [8:0]  e;                     // Oldest note
   int          bad_count, n_checks;

   ioac_cmd_unit dut (.clock(clock), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
      .cmd_ready(cmd_ready), .standalone(standalone), .host_addr(host_addr), .rep_valid(rep_valid),
      .rep_byte(rep_byte), .rep_ready(rep_ready), .exec_done(exec_done), .gp_out_0(gp_out[0]),
      .gp_out_1(gp_out[1]), .gp_out_2(gp_out[2]), .gp_out_3(gp_out[3]), .gp_in_0(gp_in[0]),
      .gp_in_1(gp_in[1]), .gp_in_2(gp_in[2]), .gp_in_3(gp_in[3]), .analog_in_0(ain[0]),
      .analog_in_1(ain[1]), .adc_value_0(adc0), .adc_value_1(adc1), .accumulator(accumulator));
   ioac_host_model host (.clock(clock), .cmd_ready(cmd_ready), .cmd_valid(cmd_valid),
      .cmd_byte(cmd_byte), .standalone(standalone), .rep_ready(rep_ready));

   // Free running clock, 50 ns period
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   // Verdict and end of run
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   // One comparison
   task automatic check(input logic [31:0] got, exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Reply watcher: old register values are read at the taking edge
   always @(posedge clock) begin
      if (rep_valid === 1'b1 && rep_ready === 1'b1) begin
         e = (exp_q.size() != 0) ? exp_q.pop_front() : 9'h1FF;
         if (e[8]) check({24'h0, rep_byte}, {24'h0, e[7:0]});
      end
   end

   // Send a frame, note its reply, wait until it is done; nchk leading bytes compared
   task automatic cmd(input logic sa, input logic [7:0] ins, typ, bnk, input logic [31:0] val,
                      input bit bad, input logic [7:0] st, input logic [31:0] rv, input int nchk);
      logic [7:0] r [9];
      bit         ok;
      int         n;
      r = '{host_addr, 8'h01, st, ins, rv[31:24], rv[23:16], rv[15:8], rv[7:0], 8'h00};
      for (int i = 0; i < 8; i++) r[8] += r[i];  // Reply sum
      if (!sa) for (int i = 0; i < 9; i++) exp_q.push_back({i < nchk, r[i]});
      host.send(sa, ins, typ, bnk, val, bad, ok);
      n = 0;
      // Direct frames end when the reply is drained, stored ones on the done pulse
      while ((sa ? exec_done !== 1'b1 : exp_q.size() != 0) && n < 100) begin
         @(negedge clock);
         n++;
      end
      if (!ok || n >= 100) begin
         bad_count++;
         $display("ERROR t=%0t hang ins=%h typ=%h", $time, ins, typ);
         tally_and_finish();
      end
   endtask

   // Main sequence
   initial begin
      rst_b = 1'b0;
      host_addr = 8'h02;
      {gp_in, ain, adc0, adc1} = '0;
      bad_count = 0;
      n_checks = 0;
      void'($urandom(32'hE6BF));
      repeat (2) @(negedge clock);
      rst_b = 1'b1;
      // Single outputs, then one cleared, read back from bank 2
      for (int p = 0; p < 4; p++) begin
         cmd(0, 8'h0E, p[7:0], 8'h02, 32'h1, 0, 8'h64, 0, 4);
         check({28'h0, gp_out}, (32'h1 << (p + 1)) - 1);
      end
      cmd(0, 8'h0E, 8'h01, 8'h02, 32'h0, 0, 8'h64, 0, 4);
      for (int p = 0; p < 4; p++) cmd(0, 8'h0F, p[7:0], 8'h02, 0, 0, 8'h64, (32'hD >> p) & 1, 9);
      cmd(0, 8'h0E, 8'hFF, 8'h02, 32'hA5, 0, 8'h64, 0, 4);
      check({28'h0, gp_out}, 32'h5);
      $display("output tests done");
      // Pin reads: digital levels and converter values of the same lines
      gp_in = 4'($urandom);
      ain = 2'($urandom);
      adc0 = 12'($urandom);
      adc1 = 12'hFFF;
      repeat (3) @(negedge clock);
      a = accumulator;
      for (int p = 0; p < 6; p++) begin
         cmd(0, 8'h0F, p[7:0], 8'h00, 0, 0, 8'h64, p < 2 ? ain[p] : gp_in[p - 2], 9);
      end
      cmd(0, 8'h0F, 8'h00, 8'h01, 0, 0, 8'h64, {20'h0, adc0}, 9);
      cmd(0, 8'h0F, 8'h01, 8'h01, 0, 0, 8'h64, {20'h0, adc1}, 9);
      check(accumulator, a);
      cmd(0, 8'h0F, 8'hFF, 8'h00, 0, 0, 8'h64, 0, 9);
      check({24'h0, accumulator[7:0]}, {28'h0, gp_in});
      cmd(0, 8'h0E, 8'hFF, 8'h02, 32'hFFFFFFFF, 0, 8'h64, 0, 4);
      check({28'h0, gp_out}, {28'h0, gp_in});
      $display("read tests done");
      // Every accumulator operation in turn, from a known start
      // A different host address, so the reply header is not a constant
      host_addr = 8'($urandom);
      cmd(0, 8'h13, 8'h09, 8'h00, 32'd1000, 0, 8'h64, 32'd1000, 9);
      x = 32'd1000;
      for (int op = 0; op < 10; op++) begin
         v = 1 + $urandom % 200;
         case (op)
            0: x = x + v;
            1: x = x - v;
            2: x = x * v;
            3: x = x / v;
            4: x = x % v;
            5: x = x & v;
            6: x = x | v;
            7: x = x ^ v;
            8: x = ~x;
            default: x = v;
         endcase
         cmd(0, 8'h13, op[7:0], 8'h00, v, 0, 8'h64, v, 9);
         check(accumulator, x);
      end
      $display("accumulator tests done");
      // Stored program read lands in the accumulator
      cmd(1, 8'h0F, 8'h00, 8'h01, 0, 0, 8'h64, 0, 0);
      check(accumulator, {20'h0, adc0});
      // Spoiled checksum is refused and changes nothing
      g = gp_out;
      cmd(0, 8'h0E, 8'hFF, 8'h02, 32'h0A, 1, ioac_pkg::ST_BAD_CSUM, 0, 3);
      check({28'h0, gp_out}, {28'h0, g});
      // Refused values, banks, types and codes, and an accepted divide by zero, leave the state alone
      cmd(0, 8'h0E, 8'h00, 8'h02, 32'h2, 0, ioac_pkg::ST_BAD_VALUE, 0, 4);
      cmd(0, 8'h0E, 8'h00, 8'h00, 32'h1, 0, ioac_pkg::ST_BAD_TYPE, 0, 4);
      check({28'h0, gp_out}, {28'h0, g});
      a = accumulator;
      cmd(0, 8'h0F, 8'h00, 8'h03, 0, 0, ioac_pkg::ST_BAD_TYPE, 0, 4);
      cmd(0, 8'h13, 8'h0A, 8'h00, 32'h5, 0, ioac_pkg::ST_BAD_TYPE, 0, 4);
      cmd(0, 8'h13, 8'h03, 8'h00, 32'h0, 0, 8'h64, 32'h0, 9);
      cmd(0, 8'h15, 8'h00, 8'h00, 32'h0, 0, ioac_pkg::ST_BAD_CMD, 0, 4);
      check(accumulator, a);
      // Negative operand travels high byte first
      cmd(0, 8'h13, 8'h09, 8'h00, 32'hFFFFEC78, 0, 8'h64, 32'hFFFFEC78, 9);
      check(accumulator, 32'hFFFFEC78);
      $display("mode and error tests done");
      tally_and_finish();
   end
endmodule
